// ===== adcss_sequencer.sv
// Purpose: converter scan sequencer with channel queue and result FIFO
// Assumes: converter busy, data and digital inputs are asynchronous pins
// Notes:   conversions requested while the converter is busy wait
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "adcss_map.svh"
module adcss_sequencer
    import adcss_pkg::*;
#(
    parameter int SDI_EN  = 1,
    parameter int QDEPTH  = `ADCSS_QUEUE_DEPTH,
    parameter int FDEPTH  = `ADCSS_FIFO_DEPTH
)
(
    input  logic            clk_i,
    input  logic            rst_i,
    input  adcss_bus_type   bus_i,
    output logic [31:0]     rdata_o,
    input  logic            converter_busy_n_i,
    input  logic [15:0]     conv_data_i,
    input  logic [3:0]      sync_digital_in_i,
    input  logic            external_pacing_clock_i,
    output logic            conv_start_o,
    output adcss_entry_type entry_o,
    output logic            simultaneous_hold_out_o
);
    localparam int QW = $clog2(QDEPTH);
    localparam int FW = $clog2(FDEPTH);

    // ****************************************************************
    // pin synchronisers and timebase
    // ****************************************************************
    logic [21:0] pin_s1, pin_s2;
    logic        busy_s2, busy_prev, ext_s2, ext_prev;
    logic [3:0]  sdi_s2;
    logic [15:0] dat_s2;
    logic [2:0]  div_reg, div_next;
    logic        ext_tb_reg;
    logic        tick;

    // only the second stage feeds logic
    assign {busy_s2, ext_s2, sdi_s2, dat_s2} = pin_s2;

    // two stages on every pin; busy idles high so reset gives no false edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_s1    <= 22'h20_0000;
            pin_s2    <= 22'h20_0000;
            busy_prev <= 1'b1;
            ext_prev  <= 1'b0;
            div_reg   <= 3'h0;
        end
        else
        begin
            pin_s1    <= {converter_busy_n_i, external_pacing_clock_i,
                          sync_digital_in_i, conv_data_i};
            pin_s2    <= pin_s1;
            busy_prev <= pin_s2[21];
            ext_prev  <= pin_s2[20];
            div_reg   <= div_next;
        end
    end

    // internal 40 MHz tick from the system clock, or external rising edge
    always_comb
    begin
        div_next = (div_reg == 3'(`ADCSS_TB_DIV - 1)) ? 3'h0 : div_reg + 3'h1;
        tick = ext_tb_reg ? (ext_s2 & ~ext_prev) : (div_reg == 3'h0);
    end

    adcss_entry_type  q_mem [QDEPTH];
    logic [15:0]      f_mem [FDEPTH];
    logic             scan_en_reg, scan_en_next, ext_tb_next;
    logic [23:0]      scan_int_reg, scan_int_next, post_ld_reg, post_ld_next;
    logic [23:0]      scnt_reg, scnt_next, left_reg, left_next;
    logic [15:0]      samp_int_reg, samp_int_next, icnt_reg, icnt_next;
    logic [8:0]       spc_reg, spc_next, iss_reg, iss_next, done_reg, done_next;
    logic [QW:0]      qlen_reg, qlen_next;
    logic [QW-1:0]    qptr_reg, qptr_next;
    logic             ovf_reg, ovf_next, run_reg, run_next, scan_reg, scan_next;
    logic             pend_reg, pend_next, start_next;
    logic [31:0]      rdata_next;
    logic             wr_q, sw_start, run_start;
    adcss_state_type  st_reg, st_next;
    adcss_entry_type  entry_next;
    logic [FW-1:0]    fwp_reg, fwp_next, frp_reg, frp_next;
    logic [FW:0]      fcnt_reg, fcnt_next;
    logic             capture, push, pop;
    logic [15:0]      result;

    // 12-bit code left aligned over the digital bits, or the full code
    function automatic logic [15:0] pack_result(input logic [15:0] d,
                                                input logic [3:0]  s);
        pack_result = (SDI_EN != 0) ? {d[15:4], s} : d;
    endfunction

    // ****************************************************************
    // register port
    // ****************************************************************
    always_comb
    begin
        scan_en_next  = scan_en_reg;
        ext_tb_next   = ext_tb_reg;
        scan_int_next = scan_int_reg;
        samp_int_next = samp_int_reg;
        post_ld_next  = post_ld_reg;
        spc_next      = spc_reg;
        qlen_next     = qlen_reg;
        wr_q          = 1'b0;
        sw_start      = 1'b0;
        run_start     = 1'b0;
        pop           = 1'b0;
        rdata_next    = 32'h0000_0000;
        if (bus_i.wr)
            case (bus_i.addr)
                `ADCSS_OFF_CTRL:
                begin
                    scan_en_next = bus_i.wdata[`ADCSS_CTRL_SCAN_EN];
                    ext_tb_next  = bus_i.wdata[`ADCSS_CTRL_EXT_TB];
                    run_start    = bus_i.wdata[`ADCSS_CTRL_SCAN_EN] & ~scan_en_reg;
                    sw_start     = bus_i.wdata[`ADCSS_CTRL_SW_START];
                    if (bus_i.wdata[`ADCSS_CTRL_Q_CLEAR]) qlen_next = '0;
                end
                `ADCSS_OFF_QUEUE:
                begin
                    // a full queue ignores further entries
                    wr_q = (qlen_reg < (QW+1)'(QDEPTH));
                    if (wr_q) qlen_next = qlen_reg + (QW+1)'(1);
                end
                `ADCSS_OFF_SCAN_INT:  scan_int_next = bus_i.wdata[23:0];
                `ADCSS_OFF_SAMP_INT:  samp_int_next = bus_i.wdata[15:0];
                `ADCSS_OFF_POST_SCAN: post_ld_next  = bus_i.wdata[23:0];
                `ADCSS_OFF_SAMPLES:   spc_next      = bus_i.wdata[8:0];
                default: ;
            endcase
        if (bus_i.rd)
            case (bus_i.addr)
                `ADCSS_OFF_CTRL:      rdata_next = {30'h0, ext_tb_reg, scan_en_reg};
                `ADCSS_OFF_SCAN_INT:  rdata_next = {8'h00, scan_int_reg};
                `ADCSS_OFF_SAMP_INT:  rdata_next = {16'h0000, samp_int_reg};
                `ADCSS_OFF_POST_SCAN: rdata_next = {8'h00, post_ld_reg};
                `ADCSS_OFF_SAMPLES:   rdata_next = {23'h0, spc_reg};
                `ADCSS_OFF_POST_LEFT: rdata_next = {8'h00, left_reg};
                `ADCSS_OFF_STATUS:
                begin
                    rdata_next[`ADCSS_ST_BUSY]      = pend_reg | (st_reg != ST_IDLE);
                    rdata_next[`ADCSS_ST_NOT_EMPTY] = (fcnt_reg != '0);
                    rdata_next[`ADCSS_ST_RUN]       = run_reg;
                    rdata_next[`ADCSS_ST_HOLD]      = scan_reg;
                    rdata_next[`ADCSS_ST_OVF]       = ovf_reg;
                    rdata_next[`ADCSS_ST_FCNT_LSB +: FW+1] = fcnt_reg;
                    rdata_next[`ADCSS_ST_QLEN_LSB +: QW+1] = qlen_reg;
                end
                `ADCSS_OFF_FIFO:
                begin
                    // reading an empty FIFO returns zero and pops nothing
                    pop = (fcnt_reg != '0);
                    rdata_next = pop ? {16'h0000, f_mem[frp_reg]} : 32'h0;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
    end

    // ****************************************************************
    // pacing and conversion sequencing
    // ****************************************************************
    always_comb
    begin
        st_next    = st_reg;
        pend_next  = pend_reg;
        qptr_next  = qptr_reg;
        scnt_next  = scnt_reg;
        icnt_next  = icnt_reg;
        left_next  = left_reg;
        run_next   = run_reg & scan_en_next;
        scan_next  = scan_reg;
        iss_next   = iss_reg;
        done_next  = done_reg;
        start_next = 1'b0;
        entry_next = entry_o;
        capture    = (st_reg == ST_HIGH) && busy_s2 && !busy_prev;
        // software start only counts outside scan mode
        if (sw_start && !scan_en_reg) pend_next = 1'b1;
        if (run_start)
        begin
            run_next  = (post_ld_reg != 24'h0);
            left_next = post_ld_reg;
            scnt_next = scan_int_reg;
            qptr_next = '0;
            scan_next = 1'b0;
        end
        else if (run_reg && tick)
        begin
            if (scnt_reg <= 24'h1)
            begin
                scnt_next = scan_int_reg;
                if (!scan_reg)
                begin
                    scan_next = 1'b1;
                    pend_next = 1'b1;
                    iss_next  = 9'h1;
                    done_next = 9'h0;
                    icnt_next = samp_int_reg;
                end
            end
            else scnt_next = scnt_reg - 24'h1;
            if (scan_reg)
            begin
                if (icnt_reg <= 16'h1)
                begin
                    icnt_next = samp_int_reg;
                    if (iss_reg < spc_reg)
                    begin
                        pend_next = 1'b1;
                        iss_next  = iss_reg + 9'h1;
                    end
                end
                else icnt_next = icnt_reg - 16'h1;
            end
        end
        case (st_reg)
            ST_IDLE:
                if (pend_reg)
                begin
                    pend_next  = 1'b0;
                    start_next = 1'b1;
                    entry_next = q_mem[qptr_reg];
                    // wrap to the first entry, queue contents kept
                    qptr_next  = ({1'b0, qptr_reg} + (QW+1)'(1) >= qlen_reg) ?
                                 '0 : qptr_reg + QW'(1);
                    st_next    = ST_START;
                end
            ST_START: st_next = ST_LOW;
            ST_LOW:   if (!busy_s2) st_next = ST_HIGH;
            ST_HIGH:  if (capture) st_next = ST_IDLE;
            default: st_next = ST_IDLE;
        endcase
        // the scan closes on its last completed conversion
        if (capture && scan_reg && !run_start)
        begin
            done_next = done_reg + 9'h1;
            if (done_reg + 9'h1 >= spc_reg)
            begin
                scan_next = 1'b0;
                left_next = left_reg - 24'h1;
                if (left_reg <= 24'h1) run_next = 1'b0;
            end
        end
        if (!scan_en_next) scan_next = 1'b0;
    end

    // ****************************************************************
    // result FIFO
    // ****************************************************************
    always_comb
    begin
        result    = pack_result(dat_s2, sdi_s2);
        push      = capture && (fcnt_reg < (FW+1)'(FDEPTH));
        fwp_next  = push ? fwp_reg + FW'(1) : fwp_reg;
        frp_next  = pop ? frp_reg + FW'(1) : frp_reg;
        fcnt_next = fcnt_reg + (FW+1)'(push) - (FW+1)'(pop);
        // a lost result wins over a clear in the same cycle
        ovf_next  = (capture && !push) ? 1'b1 :
                    (bus_i.wr && bus_i.addr == `ADCSS_OFF_CTRL &&
                     bus_i.wdata[`ADCSS_CTRL_OVF_CLR]) ? 1'b0 : ovf_reg;
    end

    // memories hold no reset, only data
    always_ff @(posedge clk_i)
    begin
        if (wr_q) q_mem[qlen_reg[QW-1:0]] <= adcss_entry_type'(bus_i.wdata[11:0]);
        if (push) f_mem[fwp_reg] <= result;
    end

    // ****************************************************************
    // state registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scan_en_reg  <= 1'b0;
            ext_tb_reg   <= 1'b0;
            scan_int_reg <= `ADCSS_RST_SCAN_INT;
            samp_int_reg <= `ADCSS_RST_SAMP_INT;
            post_ld_reg  <= `ADCSS_RST_POST_SCAN;
            spc_reg      <= `ADCSS_RST_SAMPLES;
            qlen_reg     <= '0;
            ovf_reg      <= 1'b0;
            rdata_o      <= 32'h0000_0000;
            st_reg       <= ST_IDLE;
            pend_reg     <= 1'b0;
            qptr_reg     <= '0;
            scnt_reg     <= 24'h0;
            icnt_reg     <= 16'h0;
            left_reg     <= 24'h0;
            run_reg      <= 1'b0;
            scan_reg     <= 1'b0;
            iss_reg      <= 9'h0;
            done_reg     <= 9'h0;
            conv_start_o <= 1'b0;
            entry_o      <= '0;
            fwp_reg      <= '0;
            frp_reg      <= '0;
            fcnt_reg     <= '0;
        end
        else
        begin
            scan_en_reg  <= scan_en_next;
            ext_tb_reg   <= ext_tb_next;
            scan_int_reg <= scan_int_next;
            samp_int_reg <= samp_int_next;
            post_ld_reg  <= post_ld_next;
            spc_reg      <= spc_next;
            qlen_reg     <= qlen_next;
            ovf_reg      <= ovf_next;
            rdata_o      <= rdata_next;
            st_reg       <= st_next;
            pend_reg     <= pend_next;
            qptr_reg     <= qptr_next;
            scnt_reg     <= scnt_next;
            icnt_reg     <= icnt_next;
            left_reg     <= left_next;
            run_reg      <= run_next;
            scan_reg     <= scan_next;
            iss_reg      <= iss_next;
            done_reg     <= done_next;
            conv_start_o <= start_next;
            entry_o      <= entry_next;
            fwp_reg      <= fwp_next;
            frp_reg      <= frp_next;
            fcnt_reg     <= fcnt_next;
        end
    end

    // hold stays high from scan start to the last conversion's end
    assign simultaneous_hold_out_o = scan_reg;
endmodule

// ===== adcss_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   included by the sequencer
// Summary of operation
// - result word: 12-bit value over four digital bits
// - digital bits caught at busy-low rising edge
// - 12-bit codes are two's complement, upper bits
// - 16-bit codes are two's complement, whole word
// - one conversion per software start; software polls
// - entry holds channel, gain, polarity, input configuration
// - convert entries in written order
// - wrap to first entry, keep queue contents
// - queue holds up to 512 entries
// - 24-bit scan interval counter on timebase
// - 16-bit sample interval counter on timebase
// - 24-bit post-scan count of scans
// - 9-bit samples-per-scan count
// - scan starts paced; timebase internal or external
// - drive simultaneous hold output for scan
// - each result buffered in data FIFO; dropped and flagged as overflow when full
`ifndef ADCSS_MAP_SVH
`define ADCSS_MAP_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define ADCSS_OFF_CTRL      8'h00
`define ADCSS_OFF_QUEUE     8'h04
`define ADCSS_OFF_SCAN_INT  8'h08
`define ADCSS_OFF_SAMP_INT  8'h0C
`define ADCSS_OFF_POST_SCAN 8'h10
`define ADCSS_OFF_SAMPLES   8'h14
`define ADCSS_OFF_STATUS    8'h18
`define ADCSS_OFF_FIFO      8'h1C
`define ADCSS_OFF_POST_LEFT 8'h20
// ****************************************************************
// control and status fields
// ****************************************************************
`define ADCSS_CTRL_SCAN_EN  0
`define ADCSS_CTRL_EXT_TB   1
`define ADCSS_CTRL_SW_START 2
`define ADCSS_CTRL_Q_CLEAR  3
`define ADCSS_CTRL_OVF_CLR  4
`define ADCSS_ST_BUSY       0
`define ADCSS_ST_NOT_EMPTY  1
`define ADCSS_ST_RUN        2
`define ADCSS_ST_HOLD       3
`define ADCSS_ST_OVF        4
`define ADCSS_ST_FCNT_LSB   8
`define ADCSS_ST_QLEN_LSB   16
// ****************************************************************
// reset values and timing
// ****************************************************************
`define ADCSS_RST_SCAN_INT  24'h000280
`define ADCSS_RST_SAMP_INT  16'h00A0
`define ADCSS_RST_POST_SCAN 24'h000001
`define ADCSS_RST_SAMPLES   9'h001
`define ADCSS_CLK_MHZ       200
`define ADCSS_TB_MHZ        40
`define ADCSS_TB_DIV        (`ADCSS_CLK_MHZ / `ADCSS_TB_MHZ)
`define ADCSS_QUEUE_DEPTH   512
`define ADCSS_FIFO_DEPTH    16
`endif

// ===== adcss_pkg.sv
// Purpose: types shared by the scan sequencer and its users
// Assumes: constants come from adcss_map.svh
// Notes:   input configuration codes are local encodings
package adcss_pkg;
    typedef enum logic [1:0]
    {
        grounded_single_ended     = 2'h0,
        floating_ref_single_ended = 2'h1,
        differential_input        = 2'h2
    } adcss_cfg_type;

    // one queue entry, as written to the queue register low bits
    typedef struct packed
    {
        adcss_cfg_type cfg;
        logic          unipolar;
        logic [1:0]    gain;
        logic [6:0]    channel;
    } adcss_entry_type;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } adcss_bus_type;

    // gray order along the conversion path
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_LOW   = 2'b11,
        ST_HIGH  = 2'b10
    } adcss_state_type;
endpackage

// ===== adcss_properties.sv
// Purpose: port assertions for the scan sequencer
// Assumes: converter pins are driven by the partner model
// Notes:   helper flags track scan enable and converter quiet time
`timescale 1ns/10ps
module adcss_properties
    import adcss_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire adcss_bus_type   bus_i,
    input  wire logic [31:0]     rdata_o,
    input  wire logic            converter_busy_n_i,
    input  wire logic            conv_start_o,
    input  wire adcss_entry_type entry_o,
    input  wire logic            simultaneous_hold_out_o
);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic       scan_en_reg;
    logic       scan_en_next;
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    logic       ctrl_wr;
    logic       sw_go;

    assign ctrl_wr = bus_i.wr && (bus_i.addr == 8'h00);
    // a start only counts after a quiet converter
    assign sw_go = ctrl_wr && bus_i.wdata[2] && !bus_i.wdata[0] && !scan_en_reg
                   && (quiet_reg == 4'h8) && !simultaneous_hold_out_o;

    // quiet count saturates, so a long idle stretch never wraps
    always_comb
    begin
        scan_en_next = ctrl_wr ? bus_i.wdata[0] : scan_en_reg;
        quiet_next   = quiet_reg;
        if (conv_start_o || !converter_busy_n_i)
            quiet_next = 4'h0;
        else if (quiet_reg != 4'h8)
            quiet_next = quiet_reg + 4'h1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scan_en_reg <= 1'b0;
            quiet_reg   <= 4'h8;
        end
        else
        begin
            scan_en_reg <= scan_en_next;
            quiet_reg   <= quiet_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_start_one_cycle: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    a_sw_start_once: assert property (sw_go |-> ##2 conv_start_o ##1 !conv_start_o [*4])
        else $error("software start not one conversion two cycles later");
    a_no_start_busy: assert property (!converter_busy_n_i |-> !conv_start_o)
        else $error("start while converter busy");
    a_entry_at_start: assert property ($changed(entry_o) |-> conv_start_o)
        else $error("entry changed outside a start");
    a_rdata_idle_zero: assert property (!bus_i.rd |=> rdata_o == 32'h00000000)
        else $error("read data not zero outside read answer");
    a_ctrl_pulse_bits: assert property (bus_i.rd && bus_i.addr == 8'h00 |=> rdata_o[31:2] == 30'h0)
        else $error("control pulse bits read back set");
    a_hold_needs_run: assert property ($rose(simultaneous_hold_out_o) |-> scan_en_reg)
        else $error("hold raised without scan enable");
    a_hold_first_start: assert property ($rose(simultaneous_hold_out_o) |-> ##[0:4] conv_start_o)
        else $error("scan began without first conversion");
    a_scan_start_hold: assert property (conv_start_o && scan_en_reg |-> simultaneous_hold_out_o)
        else $error("scan conversion outside hold");
    a_stop_drops_hold: assert property (ctrl_wr && !bus_i.wdata[0] |-> ##[1:3] !simultaneous_hold_out_o)
        else $error("hold kept after scan stop");

    c_sw_conv: cover property (sw_go ##2 conv_start_o);
    c_scan_conv: cover property (conv_start_o && simultaneous_hold_out_o);
    c_scan_end: cover property ($fell(simultaneous_hold_out_o));
endmodule

bind adcss_sequencer adcss_properties adcss_properties_inst
(
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .converter_busy_n_i(converter_busy_n_i), .conv_start_o(conv_start_o),
    .entry_o(entry_o), .simultaneous_hold_out_o(simultaneous_hold_out_o)
);

// ===== adcss_conv_model.sv
// Purpose: behavioural converter facing the scan sequencer
// Assumes: one conversion at a time, begun by a one-cycle start pulse
// Notes:   lines carry inverted values outside the capture window
`timescale 1ns/10ps
module adcss_conv_model
    import adcss_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            start_i,
    input  wire adcss_entry_type entry_i,
    output logic                 busy_n_o,
    output logic [15:0]          data_o,
    output logic [3:0]           sdi_o
);
    // ****************************************************************
    // conversion timing
    // ****************************************************************
    int              slow = 0;
    logic [15:0]     code_q[$];
    logic [3:0]      sdi_q[$];
    adcss_entry_type seen_q[$];
    realtime         t_q[$];
    logic [15:0]     code;
    logic [3:0]      bits;

    initial
    begin
        busy_n_o = 1'b1;
        data_o   = 16'hA5A5;
        sdi_o    = 4'h5;
    end

    // digital bits are wrong until completion, so an early capture shows up
    always @(posedge clk_i)
    begin
        if (start_i)
        begin
            seen_q.push_back(entry_i);
            t_q.push_back($realtime);
            code = (code_q.size() > 0) ? code_q.pop_front() : 16'h0000;
            bits = (sdi_q.size() > 0) ? sdi_q.pop_front() : 4'h0;
            data_o   <= ~code;
            sdi_o    <= ~bits;
            busy_n_o <= 1'b0;
            repeat (6 + slow) @(posedge clk_i);
            data_o <= code;
            sdi_o  <= bits;
            @(posedge clk_i);
            busy_n_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            data_o <= ~code;
            sdi_o  <= ~bits;
        end
    end
endmodule

// ===== adcss_sequencer_test.sv
// Purpose: self-checking bench for the scan sequencer
// Assumes: 200 MHz clock, converter played by adcss_conv_model
// Notes:   short interval counts keep the run small
`timescale 1ns/10ps
module adcss_sequencer_test
    import adcss_pkg::*;
;
    // ****************************************************************
    // stimulus and checks
    // ****************************************************************
    logic            clk_i, rst_i, busy_n, ext_clk, start, hold;
    adcss_bus_type   bus;
    logic [31:0]     rdata;
    logic [15:0]     data;
    logic [3:0]      sdi;
    adcss_entry_type entry;
    int              fails = 0;
    int              samples_checked = 0;
    adcss_entry_type q[4] = '{'{grounded_single_ended, 1'b0, 2'h0, 7'h03},
        '{differential_input, 1'b0, 2'h2, 7'h01},
        '{floating_ref_single_ended, 1'b1, 2'h1, 7'h02}, '{differential_input, 1'b0, 2'h2, 7'h01}};
    logic [15:0]     c[6] = '{16'h7FF3, 16'h0009, 16'hFFFC, 16'h8001, 16'h001E, 16'h7FF0};
    logic [3:0]      s[6] = '{4'h5, 4'h3, 4'h9, 4'h6, 4'hC, 4'h1};

    adcss_sequencer adcss_sequencer_inst
    (
        .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
        .converter_busy_n_i(busy_n), .conv_data_i(data), .sync_digital_in_i(sdi),
        .external_pacing_clock_i(ext_clk), .conv_start_o(start), .entry_o(entry),
        .simultaneous_hold_out_o(hold)
    );
    adcss_conv_model adcss_conv_model_inst
    (
        .clk_i(clk_i), .start_i(start), .entry_i(entry),
        .busy_n_o(busy_n), .data_o(data), .sdi_o(sdi)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // free-running 10 MHz external timebase
    initial
    begin
        ext_clk = 1'b0;
        forever #50 ext_clk = ~ext_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // strobes drop a cycle later, never twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(posedge clk_i);
        v = rdata;
    endtask

    task automatic wait_fifo(input int n);
        logic [31:0] v;
        for (int i = 0; i < 3000; i++)
        begin
            rd(8'h18, v);
            if (int'(v[12:8]) >= n)
                return;
        end
        fails++;
        end_sim();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic t_reset_values();
        logic [7:0]  a[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24};
        logic [31:0] e[6] = '{32'h0, 32'h280, 32'hA0, 32'h1, 32'h1, 32'h0};
        logic [31:0] v;
        for (int i = 0; i < 6; i++)
        begin
            rd(a[i], v);
            chk(v, e[i]);
        end
        $display("reset values done");
    endtask

    // six single conversions over four entries, so the queue wraps
    task automatic t_poll();
        logic [31:0] v;
        wr(8'h00, 32'h8);
        foreach (q[i]) wr(8'h04, {20'h0, q[i]});
        for (int i = 0; i < 6; i++)
        begin
            adcss_conv_model_inst.code_q.push_back(c[i]);
            adcss_conv_model_inst.sdi_q.push_back(s[i]);
            wr(8'h00, 32'h4);
            wait_fifo(1);
            rd(8'h1C, v);
            chk(v, {16'h0, c[i][15:4], s[i]});
            chk({20'h0, adcss_conv_model_inst.seen_q.pop_front()}, {20'h0, q[i % 4]});
        end
        rd(8'h18, v);
        chk(v & 32'h03FF1F00, 32'h00040000);
        $display("software polling done");
    endtask

    // paced scans; sample 14 ticks, scan 40 ticks, the given number of scans of two
    task automatic t_scan(input logic [31:0] ctl, input int scans, input realtime tick);
        logic [31:0] v;
        realtime     d;
        adcss_conv_model_inst.t_q.delete();
        wr(8'h00, 32'h8);
        wr(8'h04, {20'h0, q[1]});
        wr(8'h04, {20'h0, q[2]});
        wr(8'h0C, 32'hE);
        wr(8'h14, 32'h2);
        wr(8'h08, 32'h28);
        wr(8'h10, scans);
        for (int i = 0; i < 2 * scans; i++)
        begin
            adcss_conv_model_inst.code_q.push_back(c[i]);
            adcss_conv_model_inst.sdi_q.push_back(s[i]);
        end
        wr(8'h00, ctl);
        wait_fifo(2 * scans);
        for (int i = 0; i < 2 * scans; i++)
        begin
            rd(8'h1C, v);
            chk(v, {16'h0, c[i][15:4], s[i]});
            chk({20'h0, adcss_conv_model_inst.seen_q.pop_front()}, {20'h0, q[i % 2 + 1]});
        end
        d = adcss_conv_model_inst.t_q[1] - adcss_conv_model_inst.t_q[0];
        chk(32'(d >= 13.0 * tick && d <= 15.0 * tick), 32'h1);
        if (scans > 1)
        begin
            d = adcss_conv_model_inst.t_q[2] - adcss_conv_model_inst.t_q[0];
            chk(32'(d >= 39.0 * tick && d <= 41.0 * tick), 32'h1);
        end
        rd(8'h20, v);
        chk(v, 32'h0);
        repeat (2000) @(posedge clk_i);
        rd(8'h18, v);
        chk(v & 32'h00001F0C, 32'h0);
        chk({31'h0, hold}, 32'h0);
        rd(8'h1C, v);
        chk(v, 32'h0);
        wr(8'h00, 32'h0);
        $display("scan run done");
    endtask

    initial
    begin
        rst_i = 1'b1;
        bus   = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_values();
        t_poll();
        adcss_conv_model_inst.slow = 20;
        t_scan(32'h1, 2, 25.0);
        t_scan(32'h3, 1, 100.0);
        end_sim();
    end
endmodule
